// ==== rtl/mdfp_fault_protect.sv ====
// Design decisions made here: the register addresses and the APB register port.
`timescale 1ns/1ns
// Summary of operation
// - pump undervoltage: bridge off, pin low, flags
// - supply overvoltage: bridge off, pin low, flags
// - protection enable zero skips overvoltage actions
// - select bit picks lower or upper level
// - fet overcurrent after filter, then policy
// - latched overcurrent: off until clear command
// - retry overcurrent: resume, clear summary later
// - overcurrent flags sticky until clear command
// - buck undervoltage recorded, regulation continues
// - buck overcurrent: switches hi-z, device reset
// - comparator lock after any phase filter
// - comparator latched: coded bridge, pin, flags
// - comparator recovery: coded bridge, clears after retry
// - comparator report only: flags, keep driving
// - comparator disabled code: no action
// - adc lock after any phase filter
// - adc latched: coded bridge, pin, flags
// - adc recovery: resume and clear after retry
// - adc report only and disabled handling
// - heat warning reported: pin low, flags
// - warning holds until cool and cleared
module mdfp_fault_protect #(
  parameter int FILT_W  = 8,   // deglitch counter width
  parameter int RETRY_W = 16   // retry counter width
) (
  input  wire logic                clk,
  input  wire logic                arst_n,
  input  wire logic                psel,
  input  wire logic                penable,
  input  wire logic                pwrite,
  input  wire logic [7:0]          paddr,
  input  wire logic [31:0]         pwdata,
  output logic                     pready,
  output logic [31:0]              prdata,
  output logic                     pslverr,
  input  wire mdfp_pkg::mdfp_pins_t pinsIn,
  input  wire logic                adcValid,
  input  wire mdfp_pkg::mdfp_adc_t adcSample,
  output logic                     faultOutLow_n,
  output logic                     bridgeOff,
  output logic                     highSideOn,
  output logic                     lowSideOn,
  output logic                     buckHiZ,
  output logic                     resetReq
);
  // ---------------------------------------------------------------
  // pin synchronisers
  // ---------------------------------------------------------------
  mdfp_pkg::mdfp_pins_t pinMeta_reg; // first stage, read by second only
  mdfp_pkg::mdfp_pins_t pin_reg;     // safe copy
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      pinMeta_reg <= '0;
      pin_reg     <= '0;
    end else begin
      pinMeta_reg <= pinsIn;
      pin_reg     <= pinMeta_reg;
    end
  end
  // ---------------------------------------------------------------
  // apb registers
  // ---------------------------------------------------------------
  logic [31:0] ctrl_reg;   // control
  logic [31:0] filt_reg;   // filters
  logic [31:0] lock_reg;   // lock setup
  logic [31:0] retry_reg;  // retry times
  logic [31:0] status;     // assembled flags
  logic [31:0] rdMux;      // read selection
  wire         wrEn    = psel & penable & pwrite;      // write strike
  wire         mapped  = paddr <= mdfp_pkg::OFS_STATUS && paddr[1:0] == 2'h0;
  wire         clearCmd = wrEn && paddr == mdfp_pkg::OFS_CTRL
                          && pwdata[mdfp_pkg::CTRL_CLEAR]; // one cycle pulse
  assign pready  = 1'b1;
  assign pslverr = psel & penable & ~mapped;
  assign rdMux = (paddr == mdfp_pkg::OFS_CTRL)  ? ctrl_reg  :
                 (paddr == mdfp_pkg::OFS_FILT)  ? filt_reg  :
                 (paddr == mdfp_pkg::OFS_LOCK)  ? lock_reg  :
                 (paddr == mdfp_pkg::OFS_RETRY) ? retry_reg :
                 (paddr == mdfp_pkg::OFS_STATUS) ? status   : 32'h0000_0000;
  // register writes, clear bit self clears
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      ctrl_reg  <= mdfp_pkg::CTRL_RST;
      filt_reg  <= mdfp_pkg::FILT_RST;
      lock_reg  <= mdfp_pkg::LOCK_RST;
      retry_reg <= mdfp_pkg::RETRY_RST;
    end else if (wrEn) begin
      if (paddr == mdfp_pkg::OFS_CTRL)  ctrl_reg  <= pwdata & 32'h0000_0037;
      if (paddr == mdfp_pkg::OFS_FILT)  filt_reg  <= pwdata & 32'h00ff_ffff;
      if (paddr == mdfp_pkg::OFS_LOCK)  lock_reg  <= pwdata & 32'h0fff_00ff;
      if (paddr == mdfp_pkg::OFS_RETRY) retry_reg <= pwdata;
    end
  end
  // read data captured in setup cycle
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) prdata <= '0;
    else if (psel && !penable) prdata <= rdMux;
  end
  // ---------------------------------------------------------------
  // configuration fields
  // ---------------------------------------------------------------
  wire         protEn   = ctrl_reg[mdfp_pkg::CTRL_PROT_EN];
  wire         lvlSel   = ctrl_reg[mdfp_pkg::CTRL_LVL_SEL];
  wire         warnRep  = ctrl_reg[mdfp_pkg::CTRL_WARN_REP];
  wire [1:0]   ocPolicy = ctrl_reg[mdfp_pkg::CTRL_OC_POL +: 2];
  wire [FILT_W-1:0]  ocFilt  = filt_reg[FILT_W-1:0];
  wire [FILT_W-1:0]  lkFilt [2];
  wire [3:0]         lkPol  [2];
  wire [11:0]  adcCap   = lock_reg[27:16];
  wire [RETRY_W-1:0] drvRetry = retry_reg[RETRY_W-1:0];
  wire [RETRY_W-1:0] lkRetry  = retry_reg[16 +: RETRY_W];
  assign lkFilt[0] = filt_reg[8 +: FILT_W];
  assign lkFilt[1] = filt_reg[16 +: FILT_W];
  assign lkPol[0]  = lock_reg[3:0];
  assign lkPol[1]  = lock_reg[7:4];
  // ---------------------------------------------------------------
  // microsecond tick for retry times
  // ---------------------------------------------------------------
  // free running divider, one pulse per microsecond
  logic [7:0] tickCnt_reg;
  wire        tick = tickCnt_reg == 8'(mdfp_pkg::TICK_CYCLES - 1);
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) tickCnt_reg <= '0;
    else tickCnt_reg <= tick ? 8'h00 : tickCnt_reg + 8'h01;
  end
  // ---------------------------------------------------------------
  // adc compare, held between samples
  // ---------------------------------------------------------------
  logic adcOver_reg;
  wire  adcOverNow = adcSample.phA > adcCap || adcSample.phB > adcCap
                     || adcSample.phC > adcCap;
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) adcOver_reg <= 1'b0;
    else if (adcValid) adcOver_reg <= adcOverNow;
  end
  // ---------------------------------------------------------------
  // deglitch filters: six fets, buck, comparator lock, adc lock
  // ---------------------------------------------------------------
  localparam int NF = mdfp_pkg::NUM_FET + 3;
  logic [NF-1:0]     fRaw;      // raw condition per filter
  logic [FILT_W-1:0] fLim [NF]; // filter limit per filter
  logic [FILT_W-1:0] fCnt_reg [NF];
  logic [NF-1:0]     fHit;      // held longer than limit
  assign fRaw = {adcOver_reg, |pin_reg.phaseCmp, pin_reg.buckOc, pin_reg.fetOc};
  genvar gi;
  generate
    for (gi = 0; gi < NF; gi++) begin : g_filt
      assign fLim[gi] = (gi == NF-1) ? lkFilt[1] :
                        (gi == NF-2) ? lkFilt[0] : ocFilt;
      assign fHit[gi] = fRaw[gi] && fCnt_reg[gi] == fLim[gi];
      // count cycles the condition has held, saturating
      always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) fCnt_reg[gi] <= '0;
        else if (!fRaw[gi]) fCnt_reg[gi] <= '0;
        else if (!fHit[gi]) fCnt_reg[gi] <= fCnt_reg[gi] + 1'b1;
      end
    end
  endgenerate
  wire [mdfp_pkg::NUM_FET-1:0] fetHit = fHit[mdfp_pkg::NUM_FET-1:0];
  wire ocEvent   = |fetHit;
  wire buckOcHit = fHit[mdfp_pkg::NUM_FET];
  wire lkEvt [2];
  assign lkEvt[0] = fHit[NF-2];
  assign lkEvt[1] = fHit[NF-1];
  // ---------------------------------------------------------------
  // supply and pump live conditions
  // ---------------------------------------------------------------
  wire supHi   = lvlSel ? pin_reg.supHiHigh : pin_reg.supHiLow;
  wire supAct  = protEn & supHi;
  wire pumpAct = pin_reg.pumpUv;
  // ---------------------------------------------------------------
  // fet overcurrent state machine
  // ---------------------------------------------------------------
  mdfp_pkg::mdfp_oc_t ocState_reg;
  logic [RETRY_W-1:0] ocTimer_reg;
  wire ocRetryDone = ocState_reg == mdfp_pkg::OC_WAIT && tick
                     && ocTimer_reg >= drvRetry;
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      ocState_reg <= mdfp_pkg::OC_IDLE;
      ocTimer_reg <= '0;
    end else begin
      case (ocState_reg)
        mdfp_pkg::OC_IDLE: begin
          ocTimer_reg <= '0;
          if (ocEvent && ocPolicy == mdfp_pkg::OC_LATCH)
            ocState_reg <= mdfp_pkg::OC_HOLD;
          else if (ocEvent && ocPolicy == mdfp_pkg::OC_RETRY)
            ocState_reg <= mdfp_pkg::OC_WAIT;
        end
        mdfp_pkg::OC_HOLD: begin
          // condition gone and cleared by controller
          if (clearCmd && pin_reg.fetOc == '0)
            ocState_reg <= mdfp_pkg::OC_IDLE;
        end
        mdfp_pkg::OC_WAIT: begin
          if (tick) ocTimer_reg <= ocTimer_reg + 1'b1;
          if (ocRetryDone) ocState_reg <= mdfp_pkg::OC_IDLE;
        end
        default: ocState_reg <= mdfp_pkg::OC_IDLE;
      endcase
    end
  end
  wire ocShut   = ocState_reg != mdfp_pkg::OC_IDLE;
  wire ocReport = ocEvent && ocPolicy == mdfp_pkg::OC_REPORT;
  // ---------------------------------------------------------------
  // lock state machines: 0 comparator, 1 adc
  // ---------------------------------------------------------------
  mdfp_pkg::mdfp_lk_t lkState_reg [2];
  logic [RETRY_W-1:0] lkTimer_reg [2];
  logic [1:0] lkOff, lkHs, lkLs, lkAct, lkDone;
  generate
    for (gi = 0; gi < 2; gi++) begin : g_lock
      wire [3:0] p   = lkPol[gi];
      wire       dis = p[3] & p[0];
      wire       rep = p == mdfp_pkg::LK_REPORT_CODE;
      wire       hold = lkState_reg[gi] == mdfp_pkg::LK_HOLD
                        || lkState_reg[gi] == mdfp_pkg::LK_WAIT;
      wire       condOn = fRaw[NF-2+gi];
      assign lkDone[gi] = lkState_reg[gi] == mdfp_pkg::LK_WAIT && tick
                          && lkTimer_reg[gi] >= lkRetry;
      // coded bridge state while holding
      assign lkHs[gi]  = hold && p[1:0] == 2'h2;
      assign lkLs[gi]  = hold && p[1:0] == 2'h3;
      assign lkOff[gi] = hold && !p[1];
      assign lkAct[gi] = lkState_reg[gi] != mdfp_pkg::LK_IDLE;
      always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
          lkState_reg[gi] <= mdfp_pkg::LK_IDLE;
          lkTimer_reg[gi] <= '0;
        end else begin
          case (lkState_reg[gi])
            mdfp_pkg::LK_IDLE: begin
              lkTimer_reg[gi] <= '0;
              if (lkEvt[gi] && !dis) begin
                if (p[3:2] == 2'h0)
                  lkState_reg[gi] <= mdfp_pkg::LK_HOLD;
                else if (p[3:2] == 2'h1)
                  lkState_reg[gi] <= mdfp_pkg::LK_WAIT;
                else if (rep)
                  lkState_reg[gi] <= mdfp_pkg::LK_SHOW;
              end
            end
            mdfp_pkg::LK_HOLD, mdfp_pkg::LK_SHOW: begin
              if (clearCmd && !condOn)
                lkState_reg[gi] <= mdfp_pkg::LK_IDLE;
            end
            mdfp_pkg::LK_WAIT: begin
              if (tick) lkTimer_reg[gi] <= lkTimer_reg[gi] + 1'b1;
              if (lkDone[gi])
                lkState_reg[gi] <= mdfp_pkg::LK_IDLE;
            end
            default: lkState_reg[gi] <= mdfp_pkg::LK_IDLE;
          endcase
        end
      end
    end
  endgenerate
  // ---------------------------------------------------------------
  // sticky flags, set wins over clear
  // ---------------------------------------------------------------
  logic drvSum_reg, pumpFlag_reg, supFlag_reg, ocFlag_reg, regLow_reg;
  logic heatFlag_reg, warnFlag_reg;
  logic [mdfp_pkg::NUM_FET-1:0] fetFlag_reg;
  wire  ocSet   = ocEvent && ocPolicy != 2'h3;
  wire  warnSet = warnRep && pin_reg.heatWarn;
  wire  drvSet  = pumpAct | supAct | ocSet;
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      drvSum_reg <= 1'b0;
      pumpFlag_reg <= 1'b0;
      supFlag_reg <= 1'b0;
      ocFlag_reg <= 1'b0;
      fetFlag_reg <= '0;
      regLow_reg <= 1'b0;
      heatFlag_reg <= 1'b0;
      warnFlag_reg <= 1'b0;
    end else begin
      drvSum_reg   <= drvSet | (drvSum_reg & ~clearCmd & ~ocRetryDone);
      pumpFlag_reg <= pumpAct | (pumpFlag_reg & ~clearCmd);
      supFlag_reg  <= supAct | (supFlag_reg & ~clearCmd);
      ocFlag_reg   <= ocSet | (ocFlag_reg & ~clearCmd);
      fetFlag_reg  <= (ocSet ? fetHit : '0)
                      | (fetFlag_reg & {mdfp_pkg::NUM_FET{~clearCmd}});
      regLow_reg   <= pin_reg.buckUv | (regLow_reg & ~clearCmd);
      // warning releases only when cool and cleared
      heatFlag_reg <= warnSet | (heatFlag_reg & ~(clearCmd & pin_reg.heatCool));
      warnFlag_reg <= warnSet | (warnFlag_reg & ~(clearCmd & pin_reg.heatCool));
    end
  end
  // controller summary follows any lock machine that is not idle
  wire ctrlSum = |lkAct;
  assign status = {16'h0000, fetFlag_reg, regLow_reg, warnFlag_reg, heatFlag_reg,
                   lkAct[1], lkAct[0], ctrlSum, ocFlag_reg, supFlag_reg,
                   pumpFlag_reg, drvSum_reg};
  // ---------------------------------------------------------------
  // bridge, pin and buck outputs
  // ---------------------------------------------------------------
  wire drvOff   = pumpAct | supAct | ocShut;
  wire offAll   = drvOff | (|lkOff);
  wire pinReq   = drvOff | ocReport | ctrlSum | warnFlag_reg;
  // off beats both clamps, comparator lock beats adc lock
  wire hsNext   = !offAll && lkHs[0] | (!offAll && !lkLs[0] && lkHs[1]);
  wire lsNext   = !offAll && !lkHs[0] && (lkLs[0] | (!lkHs[1] && lkLs[1]));
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      faultOutLow_n <= 1'b1;
      bridgeOff     <= 1'b0;
      highSideOn    <= 1'b0;
      lowSideOn     <= 1'b0;
      buckHiZ       <= 1'b0;
      resetReq      <= 1'b0;
    end else begin
      faultOutLow_n <= ~pinReq;
      bridgeOff     <= offAll;
      highSideOn    <= hsNext;
      lowSideOn     <= lsNext;
      buckHiZ       <= buckHiZ | buckOcHit;
      resetReq      <= resetReq | buckOcHit;
    end
  end
  // ---------------------------------------------------------------
  // assertions
  // ---------------------------------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (!arst_n);
  property p_pump;
    pumpAct |=> bridgeOff && !faultOutLow_n && pumpFlag_reg && drvSum_reg;
  endproperty
  a_pump: assert property (p_pump) else $error("pump fault not acted");
  property p_sup;
    supAct |=> bridgeOff && supFlag_reg;
  endproperty
  a_sup: assert property (p_sup) else $error("supply fault not acted");
  property p_supoff;
    !protEn && !pumpAct && !ocShut && lkOff == 2'h0 |=> !supFlag_reg || $past(supFlag_reg);
  endproperty
  a_supoff: assert property (p_supoff) else $error("disabled supply acted");
  property p_latch;
    ocState_reg == mdfp_pkg::OC_HOLD && !clearCmd |=> ocState_reg == mdfp_pkg::OC_HOLD;
  endproperty
  a_latch: assert property (p_latch) else $error("latched fault released");
  property p_ocflag;
    ocFlag_reg && !clearCmd |=> ocFlag_reg;
  endproperty
  a_ocflag: assert property (p_ocflag) else $error("overcurrent flag lost");
  property p_buck;
    buckOcHit |=> buckHiZ && resetReq;
  endproperty
  a_buck: assert property (p_buck) else $error("buck overcurrent missed");
  property p_lkdis;
    lkState_reg[0] == mdfp_pkg::LK_IDLE && lkPol[0][3] && lkPol[0][0]
      |=> lkState_reg[0] == mdfp_pkg::LK_IDLE;
  endproperty
  a_lkdis: assert property (p_lkdis) else $error("disabled lock acted");
  property p_lkrep;
    lkState_reg[1] == mdfp_pkg::LK_SHOW && lkState_reg[0] == mdfp_pkg::LK_IDLE && !drvOff
      |=> !bridgeOff && !highSideOn && !lowSideOn;
  endproperty
  a_lkrep: assert property (p_lkrep) else $error("report mode drove bridge");
  property p_warn;
    warnFlag_reg && !(clearCmd && pin_reg.heatCool) |=> warnFlag_reg ##0 !faultOutLow_n;
  endproperty
  a_warn: assert property (p_warn) else $error("warning released early");
  property p_pin;
    pinReq |=> !faultOutLow_n;
  endproperty
  a_pin: assert property (p_pin) else $error("fault pin not low");
endmodule : mdfp_fault_protect

// ==== rtl/mdfp_pkg.sv ====
package mdfp_pkg;
  // ---------------------------------------------------------------
  // register byte offsets
  // ---------------------------------------------------------------
  localparam logic [7:0] OFS_CTRL   = 8'h00; // control and clear command
  localparam logic [7:0] OFS_FILT   = 8'h04; // deglitch filters
  localparam logic [7:0] OFS_LOCK   = 8'h08; // lock policies and adc cap
  localparam logic [7:0] OFS_RETRY  = 8'h0c; // retry times
  localparam logic [7:0] OFS_STATUS = 8'h10; // sticky flags, read only
  // ---------------------------------------------------------------
  // field positions and reset values
  // ---------------------------------------------------------------
  localparam int CTRL_PROT_EN  = 0;  // supply high protection enable
  localparam int CTRL_LVL_SEL  = 1;  // 0: lower level, 1: upper level
  localparam int CTRL_WARN_REP = 2;  // heat warning reporting enable
  localparam int CTRL_OC_POL   = 4;  // two bit overcurrent policy
  localparam int CTRL_CLEAR    = 8;  // write one: clear fault command
  localparam logic [31:0] CTRL_RST  = 32'h0000_0001;
  localparam logic [31:0] FILT_RST  = 32'h0010_1010;
  localparam logic [31:0] LOCK_RST  = 32'h0fff_0099;
  localparam logic [31:0] RETRY_RST = 32'h03e8_03e8;
  // ---------------------------------------------------------------
  // policy codes and timing
  // ---------------------------------------------------------------
  localparam logic [1:0] OC_LATCH  = 2'h0;
  localparam logic [1:0] OC_RETRY  = 2'h1;
  localparam logic [1:0] OC_REPORT = 2'h2;
  localparam logic [3:0] LK_REPORT_CODE = 4'h8;
  localparam int CLK_PERIOD_NS = 10;    // 100 MHz
  localparam int RETRY_TICK_NS = 1000;  // retry times count in us
  localparam int TICK_CYCLES   = RETRY_TICK_NS / CLK_PERIOD_NS;
  localparam int NUM_FET       = 6;
  // ---------------------------------------------------------------
  // types
  // ---------------------------------------------------------------
  typedef enum {OC_IDLE, OC_HOLD, OC_WAIT}             mdfp_oc_t;
  typedef enum {LK_IDLE, LK_HOLD, LK_WAIT, LK_SHOW}    mdfp_lk_t;
  typedef struct packed {
    logic                pumpUv;     // charge pump below limit
    logic                supHiLow;   // supply above lower level
    logic                supHiHigh;  // supply above upper level
    logic [NUM_FET-1:0]  fetOc;      // per fet current above level
    logic                buckUv;     // buck feedback below limit
    logic                buckOc;     // buck high side above limit
    logic [2:0]          phaseCmp;   // phase comparators above cap
    logic                heatWarn;   // fet above warning limit
    logic                heatCool;   // fet below warning hysteresis
  } mdfp_pins_t;
  typedef struct packed {
    logic [11:0] phA;
    logic [11:0] phB;
    logic [11:0] phC;
  } mdfp_adc_t;
endpackage : mdfp_pkg

// ==== bench/mdfp_ctrl_model.sv ====
`timescale 1ns/1ns
// ---------------------------------------------------------------
// system controller: watches the fault pin and wants a clear
// ---------------------------------------------------------------
module mdfp_ctrl_model (
  input  wire logic clk,
  input  wire logic arst_n,
  input  wire logic faultOutLow_n,
  input  wire logic clearAck,
  output logic      clearWanted
);
  // a low pin is remembered until the clear has gone out
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) clearWanted <= 1'b0;
    else if (clearAck) clearWanted <= 1'b0;
    else if (faultOutLow_n === 1'b0) clearWanted <= 1'b1;
  end
endmodule : mdfp_ctrl_model

// ==== bench/mdfp_fault_protect_tb_top.sv ====
`timescale 1ns/1ns
module mdfp_fault_protect_tb_top;
  typedef struct {logic [32:0] e; logic [32:0] m;} mdfp_note_t;
  localparam logic [7:0] ST = mdfp_pkg::OFS_STATUS;
  logic clk, arst_n, psel, penable, pwrite, pready, pslverr, adcValid, ack, seen, hot;
  logic faultOutLow_n, bridgeOff, highSideOn, lowSideOn, buckHiZ, resetReq;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata;
  mdfp_pkg::mdfp_pins_t pinsIn, idle, p;
  mdfp_pkg::mdfp_adc_t adcSample;
  mdfp_note_t q[$], nt;
  logic [32:0] lkS;  // lock flags expected for the lock under test
  int seed, k, failures, compares;
  logic [31:0] rv [4] = '{mdfp_pkg::CTRL_RST, mdfp_pkg::FILT_RST, mdfp_pkg::LOCK_RST,
                          mdfp_pkg::RETRY_RST};
  // lock policy table: code, outputs during, outputs after, flags
  logic [3:0] lc [6] = '{4'h1, 4'h2, 4'h3, 4'h5, 4'h8, 4'h9};
  logic [3:0] lOn [6] = '{4'h4, 4'h2, 4'h1, 4'h4, 4'h0, 4'h8};
  logic [3:0] lOm [6] = '{4'hf, 4'hf, 4'hf, 4'hf, 4'h7, 4'hf};
  logic [3:0] lOff [6] = '{4'h4, 4'h2, 4'h1, 4'h8, 4'h0, 4'h8};
  logic [5:0] lF = 6'b011111;
  logic [5:0] lF2 = 6'b010111;

  mdfp_fault_protect #(.FILT_W(8), .RETRY_W(16)) DUT (.clk, .arst_n, .psel, .penable,
    .pwrite, .paddr, .pwdata, .pready, .prdata, .pslverr, .pinsIn, .adcValid, .adcSample,
    .faultOutLow_n, .bridgeOff, .highSideOn, .lowSideOn, .buckHiZ, .resetReq);
  mdfp_ctrl_model uCtrl (.clk, .arst_n, .faultOutLow_n, .clearAck(ack), .clearWanted(seen));

  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  // adc feed: phase b above the cap while hot
  always @(posedge clk) begin
    adcValid <= ~adcValid;
    adcSample.phA <= 12'($unsigned($random(seed)) % 256);
    adcSample.phB <= hot ? 12'h101 + 12'($unsigned($random(seed)) % 1024) : 12'h0ff;
  end
  // read monitor: oldest note against each completed read
  always @(posedge clk) begin
    if (psel && penable && !pwrite && pready === 1'b1 && q.size() > 0) begin
      nt = q.pop_front();
      chk({pslverr, prdata} & nt.m, nt.e);
    end
  end

  function automatic logic [32:0] outs();
    return {29'h0, faultOutLow_n, bridgeOff, highSideOn, lowSideOn};
  endfunction : outs
  task automatic chk(input logic [32:0] s, input logic [32:0] e);
    compares++;
    if (s !== e) begin
      failures++;
      $display("ERROR t=%0t seen=%h exp=%h", $time, s, e);
    end
  endtask : chk
  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
  endtask : cyc
  // apb transfer, held until pready is sampled high
  task automatic apb(input logic w, input logic [7:0] a, input logic [32:0] d, m);
    if (!w) q.push_back('{d & m, m});
    @(posedge clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d[31:0];
    @(posedge clk);
    penable <= 1'b1;
    do @(posedge clk); while (pready !== 1'b1);
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, {1'b0, d}, '0);
  endtask : wr
  task automatic rd(input logic [7:0] a, input logic [32:0] e, m);
    apb(1'b0, a, e, m);
  endtask : rd
  task automatic clr(input logic [31:0] c);
    wr(mdfp_pkg::OFS_CTRL, c | (32'h1 << mdfp_pkg::CTRL_CLEAR));
    ack <= 1'b1;
    @(posedge clk);
    ack <= 1'b0;
  endtask : clr
  // raise a condition, drop it, clear if anything was flagged or the pin went low, then expect idle
  task automatic run(input mdfp_pkg::mdfp_pins_t pv, input logic h, input logic [3:0] on, om,
                     off, input logic [32:0] s, m, s2, m2, input logic [31:0] c);
    wr(mdfp_pkg::OFS_CTRL, c);
    pinsIn <= pv;
    hot <= h;
    cyc(20);
    chk(outs() & {29'h0, om}, {29'h0, on & om});
    rd(ST, s, m);
    pinsIn <= idle;
    hot <= 1'b0;
    cyc(250);
    chk(outs() & {29'h0, om}, {29'h0, off & om});
    rd(ST, s2, m2);
    if (seen === 1'b1 || s !== 33'h0) clr(c);
    cyc(20);
    chk(outs(), 33'h8);
    rd(ST, 33'h0, '1);
  endtask : run
  task automatic report_and_stop();
    $display("compares=%0d failures=%0d", compares, failures);
    if (failures == 0 && compares > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask : report_and_stop

  initial begin
    repeat (40000) @(posedge clk);
    failures++;
    report_and_stop();
  end
  // ---------------------------------------------------------------
  // main sequence
  // ---------------------------------------------------------------
  initial begin
    seed = 28488;
    {psel, penable, pwrite, paddr, pwdata, adcValid, ack, hot, adcSample} = '0;
    idle = '0;
    idle.heatCool = 1'b1;
    pinsIn = idle;
    arst_n = 1'b0;
    cyc(20);
    arst_n <= 1'b1;
    for (int i = 0; i < 4; i++) rd(8'(i * 4), {1'b0, rv[i]}, '1);
    rd(8'h14, 33'h1_0000_0000, '1);
    wr(mdfp_pkg::OFS_FILT, 32'h0004_0404);
    wr(mdfp_pkg::OFS_RETRY, 32'h0001_0001);
    p = idle;
    p.pumpUv = 1'b1;
    run(p, 0, 4'h4, 4'hf, 4'h8, 33'h3, 33'h3, 33'h2, 33'h2, 32'h1);
    p = idle;
    p.supHiLow = 1'b1;
    run(p, 0, 4'h4, 4'hf, 4'h8, 33'h5, 33'h5, 33'h4, 33'h4, 32'h1);
    run(p, 0, 4'h8, 4'hf, 4'h8, 33'h0, '1, 33'h0, '1, 32'h3);
    p.supHiHigh = 1'b1;
    run(p, 0, 4'h4, 4'hf, 4'h8, 33'h5, 33'h5, 33'h4, 33'h4, 32'h3);
    run(p, 0, 4'h8, 4'hf, 4'h8, 33'h0, '1, 33'h0, '1, 32'h0);
    for (int i = 0; i < 3; i++) begin
      k = $unsigned($random(seed)) % 6;
      p = idle;
      p.fetOc[k] = 1'b1;
      run(p, 0, i == 2 ? 4'h0 : 4'h4, 4'hf, i ? 4'h8 : 4'h4,
          33'h9 | (33'h1 << (10 + k)), '1,
          (33'h9 | (33'h1 << (10 + k))) & ~33'(i == 1), '1, 32'h1 | (32'(i) << 4));
    end
    p = idle;
    p.buckUv = 1'b1;
    run(p, 0, 4'h0, 4'h7, 4'h0, 33'h200, 33'h200, 33'h200, 33'h200, 32'h1);
    p = idle;
    p.heatWarn = 1'b1;
    p.heatCool = 1'b0;
    wr(mdfp_pkg::OFS_CTRL, 32'h5);
    pinsIn <= p;
    cyc(20);
    pinsIn.heatWarn <= 1'b0;
    clr(32'h5);
    cyc(20);
    chk(outs(), 33'h0);
    run(p, 0, 4'h0, 4'hf, 4'h0, 33'h180, 33'h180, 33'h100, 33'h100, 32'h5);
    for (int j = 0; j < 2; j++)
      for (int i = 0; i < 6; i++) begin
        wr(mdfp_pkg::OFS_LOCK, j ? {16'h0100, 8'h0, lc[i], 4'h9} : {16'h0100, 8'h0, 4'h9, lc[i]});
        p = idle;
        p.phaseCmp[$unsigned($random(seed)) % 3] = (j == 0);
        lkS = 33'h10 | (33'h20 << j);
        run(p, j == 1, lOn[i], lOm[i], lOff[i], lF[i] ? lkS : 33'h0, '1,
            lF2[i] ? lkS : 33'h0, '1, 32'h1);
      end
    // buck overcurrent stays until a reset, then a mid-run reset clears it
    p = idle;
    p.buckOc = 1'b1;
    pinsIn <= p;
    cyc(20);
    pinsIn <= idle;
    cyc(5);
    chk({31'h0, buckHiZ, resetReq}, 33'h3);
    arst_n <= 1'b0;
    cyc(2);
    arst_n <= 1'b1;
    cyc(3);
    chk({31'h0, buckHiZ, resetReq}, 33'h0);
    chk(outs(), 33'h8);
    rd(ST, 33'h0, '1);
    report_and_stop();
  end
endmodule : mdfp_fault_protect_tb_top
